// ===== design/lbalu_pkg.sv
// package for the logic and bit operation datapath
// assumes an 8-bit core with a flags register and a 16-entry working file
package lbalu_pkg;

    // register bus map, byte addresses of aligned 32-bit words
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_OPER    = 8'h04;
    localparam logic [7:0] ADDR_FLAGS   = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_REGBASE = 8'h40;

    // control register fields
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_SRC_LSB  = 8;
    localparam int CTRL_BYTE_LSB = 16;

    // flags register address inside the core and flag positions
    localparam logic [7:0] FLAGS_CORE_ADDR = 8'hD5;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;

    // opcodes
    localparam logic [7:0] OPC_AND_RR  = 8'h52;
    localparam logic [7:0] OPC_BAND    = 8'h67;
    localparam logic [7:0] OPC_BCP     = 8'h17;
    localparam logic [7:0] OPC_BINV    = 8'h57;
    localparam logic [7:0] OPC_BCLRSET = 8'h77;
    localparam logic [7:0] OPC_ADD_RR  = 8'h02;

    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] REG_RST   = 8'h00;

    // an instruction stays busy this many cycles plus two after launch
    localparam int EXEC_CYCLES = 4;

    localparam logic [31:0] BUS_RST = 32'h0000_0000;
    localparam logic [1:0]  RESP_OK  = 2'b00;
    localparam logic [1:0]  RESP_ERR = 2'b10;

    // second instruction byte fields
    typedef struct packed {
        logic [3:0] regAddr;
        logic [2:0] bitIdx;
        logic       lsbSel;
    } lbalu_byte2_t;

endpackage

// ===== design/lbalu_if.sv
// port bundle between the datapath and its working register file
// assumes one synchronous write port and one registered read port
`timescale 1ns/1ps
interface lbalu_if;
    logic [3:0] wrAddr;
    logic [7:0] wrData;
    logic       wrEn;
    logic [3:0] rdAddr;
    logic [7:0] rdData;
    modport core (output wrAddr, wrData, wrEn, rdAddr, input rdData);
    modport mem  (input wrAddr, wrData, wrEn, rdAddr, output rdData);
endinterface

// ===== design/lbalu_regfile.sv
// sixteen-byte working register file with registered read data
// assumes one writer and synchronous reset
`timescale 1ns/1ps
module lbalu_regfile
    import lbalu_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    lbalu_if.mem      rf
);
    typedef struct packed {
        logic [15:0][7:0] mem;
        logic [7:0]       rdData;
    } lbalu_rf_t;

    lbalu_rf_t st;
    lbalu_rf_t next_st;

    // read is taken before the write lands so a read of the same entry sees old data
    always_comb begin
        next_st = st;
        next_st.rdData = st.mem[rf.rdAddr];
        if (rf.wrEn) begin
            next_st.mem[rf.wrAddr] = rf.wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.mem    <= {16{REG_RST}};
            st.rdData <= REG_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rf.rdData = st.rdData;
endmodule

// ===== design/lbalu_top.sv
// logic and single-bit operation datapath with an AXI4-Lite slave
// assumes a single clock, synchronous active-high reset, one master
`timescale 1ns/1ps
module lbalu_top
    import lbalu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum {IDLE, RD_DST, RD_SRC, EXEC, DONE} lbalu_state_t;

    typedef struct packed {
        lbalu_state_t fsm;
        logic [7:0]   opcode;
        logic [7:0]   byte2;
        logic [3:0]   srcAddr;
        logic [7:0]   dstVal;
        logic [7:0]   srcVal;
        logic [7:0]   flags;
        logic         busy;
        logic         doneSticky;
        logic         badOp;
        logic [2:0]   waitCnt;
        logic         awHeld;
        logic [7:0]   awAddr;
        logic         wHeld;
        logic [31:0]  wData;
        logic [3:0]   wStrb;
        logic         bValid;
        logic [1:0]   bResp;
        logic         rValid;
        logic [31:0]  rData;
        logic [1:0]   rResp;
        logic         rdRegPend;
        logic         swWrEn;
        logic [3:0]   swWrAddr;
        logic [7:0]   swWrData;
        logic         wbEn;
        logic [3:0]   wbAddr;
        logic [7:0]   wbData;
        logic         awRdy;
        logic         wRdy;
        logic         arRdy;
    } lbalu_st_t;

    lbalu_st_t st;
    lbalu_st_t next_st;
    lbalu_byte2_t b2;
    logic [7:0] res;
    logic       writeBack;
    logic [7:0] newFlags;
    logic [3:0] rdSel;

    lbalu_if rfBus ();

    lbalu_regfile u_regfile (
        .clk (clk),
        .rst (rst),
        .rf  (rfBus.mem)
    );

    // true when a word address selects the register file window
    function automatic logic isRegWin(input logic [7:0] a);
        return a[7:6] == ADDR_REGBASE[7:6];
    endfunction

    // merge each strobed byte lane into a 32-bit word
    function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // operand split of the second byte
    assign b2 = lbalu_byte2_t'(st.byte2);

    // datapath result and flag update, used only in DONE
    always_comb begin
        res       = st.dstVal;
        writeBack = 1'b1;
        newFlags  = st.flags;
        case (st.opcode)
            OPC_AND_RR: begin
                res = st.dstVal & st.srcVal;
                newFlags[FLAG_Z] = (res == 8'h00);
                newFlags[FLAG_S] = res[7];
                newFlags[FLAG_V] = 1'b0;
            end
            OPC_BAND: begin
                if (!b2.lsbSel) begin
                    res[0] = st.dstVal[0] & st.srcVal[b2.bitIdx];
                end else begin
                    res[b2.bitIdx] = st.dstVal[b2.bitIdx]
                                     & st.srcVal[0];
                end
                // zero judged on the whole destination byte
                newFlags[FLAG_Z] = (res == 8'h00);
                newFlags[FLAG_S] = 1'b0;
            end
            OPC_BCP: begin
                writeBack = 1'b0;
                newFlags[FLAG_Z] = st.dstVal[0]
                                   == st.srcVal[b2.bitIdx];
                newFlags[FLAG_S] = 1'b0;
            end
            OPC_BINV: begin
                res[b2.bitIdx] = ~st.dstVal[b2.bitIdx];
                newFlags[FLAG_Z] = (res == 8'h00);
                newFlags[FLAG_S] = 1'b0;
            end
            OPC_BCLRSET: begin
                res[b2.bitIdx] = b2.lsbSel;
            end
            OPC_ADD_RR: begin
                res = 8'(st.dstVal + st.srcVal);
            end
            default: begin
                writeBack = 1'b0;
            end
        endcase
    end

    // register file read select: fsm in fetch and execute, software read in IDLE, write address otherwise
    always_comb begin
        case (st.fsm)
            RD_DST: rdSel = b2.regAddr;
            // source held through execute so its data stays put
            RD_SRC, EXEC: rdSel = st.srcAddr;
            default: rdSel = st.awAddr[5:2];
        endcase
        if (st.fsm == IDLE) rdSel = s_axi_araddr[5:2];
    end

    assign rfBus.rdAddr = rdSel;
    assign rfBus.wrEn   = st.wbEn | st.swWrEn;
    assign rfBus.wrAddr = st.wbEn ? st.wbAddr : st.swWrAddr;
    assign rfBus.wrData = st.wbEn ? st.wbData : st.swWrData;

    // next-state logic: bus slave and execution sequencer
    always_comb begin
        next_st = st;
        next_st.wbEn   = 1'b0;
        next_st.swWrEn = 1'b0;

        // write address and data are taken independently
        if (s_axi_awvalid && !st.awHeld) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.wHeld) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.bValid && s_axi_bready) next_st.bValid = 1'b0;
        if (st.rValid && s_axi_rready) next_st.rValid = 1'b0;

        // writes are held off while an instruction runs
        if (st.awHeld && st.wHeld && !st.bValid && !st.busy) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = RESP_OK;
            if (st.awAddr == ADDR_CTRL) begin
                if (st.wStrb[0]) begin
                    next_st.opcode = st.wData[CTRL_OP_LSB +: 8];
                    next_st.busy   = 1'b1;
                    next_st.fsm    = RD_DST;
                    next_st.doneSticky = 1'b0;
                end
                if (st.wStrb[1]) begin
                    next_st.srcAddr = st.wData[CTRL_SRC_LSB +: 4];
                end
                if (st.wStrb[2]) begin
                    next_st.byte2 = st.wData[CTRL_BYTE_LSB +: 8];
                end
            end else if (st.awAddr == ADDR_FLAGS) begin
                next_st.flags = 8'(strbMerge({24'h0, st.flags},
                                             st.wData, st.wStrb));
            end else if (isRegWin(st.awAddr)) begin
                next_st.swWrEn   = st.wStrb[0];
                next_st.swWrAddr = st.awAddr[5:2];
                next_st.swWrData = st.wData[7:0];
            end else begin
                next_st.bResp = RESP_ERR;
            end
        end

        // reads: file window needs one extra cycle for registered data
        if (st.rdRegPend) begin
            next_st.rdRegPend = 1'b0;
            next_st.rValid    = 1'b1;
            next_st.rData     = {24'h0, rfBus.rdData};
        end else if (s_axi_arvalid && !st.rValid && st.fsm == IDLE) begin
            next_st.rResp = RESP_OK;
            if (isRegWin(s_axi_araddr)) begin
                next_st.rdRegPend = 1'b1;
            end else begin
                next_st.rValid = 1'b1;
                case (s_axi_araddr)
                    ADDR_CTRL:   next_st.rData = {8'h00, st.byte2,
                                                  4'h0, st.srcAddr,
                                                  st.opcode};
                    ADDR_FLAGS:  next_st.rData = {24'h0, st.flags};
                    ADDR_STATUS: next_st.rData = {29'h0, st.badOp,
                                                  st.doneSticky,
                                                  st.busy};
                    ADDR_OPER:   next_st.rData = {16'h0, st.srcVal,
                                                  st.dstVal};
                    default: begin
                        next_st.rData = BUS_RST;
                        next_st.rResp = RESP_ERR;
                    end
                endcase
            end
        end

        // sequencer: fetch dst, fetch src, execute, commit
        case (st.fsm)
            IDLE: begin
            end
            RD_DST: begin
                next_st.fsm = RD_SRC;
            end
            RD_SRC: begin
                next_st.dstVal = rfBus.rdData;
                next_st.fsm    = EXEC;
                next_st.waitCnt = 3'(EXEC_CYCLES - 2);
            end
            EXEC: begin
                next_st.srcVal = rfBus.rdData;
                if (st.waitCnt == 3'h0) next_st.fsm = DONE;
                else next_st.waitCnt = st.waitCnt - 3'h1;
            end
            DONE: begin
                // flags land at this edge, the result one edge later through wbEn
                next_st.wbEn   = writeBack;
                next_st.wbAddr = b2.regAddr;
                next_st.wbData = res;
                next_st.flags  = newFlags;
                next_st.badOp  = !(st.opcode inside {OPC_AND_RR,
                                   OPC_BAND, OPC_BCP, OPC_BINV,
                                   OPC_BCLRSET, OPC_ADD_RR});
                next_st.busy   = 1'b0;
                next_st.doneSticky = 1'b1;
                next_st.fsm    = IDLE;
            end
            default: next_st.fsm = IDLE;
        endcase

        // readies registered; reads stall while the sequencer owns the file
        next_st.awRdy = !next_st.awHeld;
        next_st.wRdy  = !next_st.wHeld;
        next_st.arRdy = !next_st.rValid && !next_st.rdRegPend
                        && next_st.fsm == IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.fsm <= IDLE;
            st.flags <= FLAGS_RST;
            st.awRdy <= 1'b1;
            st.wRdy  <= 1'b1;
            st.arRdy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // bus outputs straight from state flops
    assign s_axi_awready = st.awRdy;
    assign s_axi_wready  = st.wRdy;
    assign s_axi_bvalid  = st.bValid;
    assign s_axi_bresp   = st.bResp;
    assign s_axi_arready = st.arRdy;
    assign s_axi_rvalid  = st.rValid;
    assign s_axi_rdata   = st.rData;
    assign s_axi_rresp   = st.rResp;
endmodule

// ===== tb/lbalu_top_props.sv
// bus answer checks for the logic and bit operation datapath
// assumes binding to lbalu_top, one clock, synchronous reset
`timescale 1ns/1ps
module lbalu_top_props
    import lbalu_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // answers stand until the master takes them
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed while waiting");
    rvalid_release_a: assert property ($fell(s_axi_rvalid)
        |-> $past(s_axi_rready)) else $error("read answer withdrawn");
    bvalid_release_a: assert property ($fell(s_axi_bvalid)
        |-> $past(s_axi_bready)) else $error("write answer withdrawn");
    rresp_legal_a: assert property (s_axi_rvalid
        |-> s_axi_rresp == RESP_OK || s_axi_rresp == RESP_ERR)
        else $error("illegal read response");
    // a taken read is answered within two cycles at most
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    flags_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_FLAGS
        |=> s_axi_rvalid && s_axi_rresp == RESP_OK
            && s_axi_rdata[31:8] == 24'h000000)
        else $error("flags read answer wrong");
    // hole in the map: error code and zero data
    unmapped_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_ERR
            && s_axi_rdata == BUS_RST))
        else $error("unmapped read not refused");
endmodule

// ===== tb/lbalu_top_tb.sv
// self-checking bench for the logic and bit operation datapath
// assumes lbalu_top and its package; the bench is the bus master
`timescale 1ns/1ps
module lbalu_top_tb
    import lbalu_pkg::*;
;
    localparam int LIM = 200;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          errors = 0;
    int          comparisons = 0;

    lbalu_top DUT (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // free-running core clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic bail();
        errors++;
        $display("mismatch bus wait expected answer seen none");
        results();
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // each call waits one edge first so no signal is set twice per step
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] st, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < LIM);
        if (s_axi_bvalid !== 1'h1) bail();
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < LIM);
        if (s_axi_rvalid !== 1'h1) bail();
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    function automatic logic [7:0] regAddr(input logic [3:0] n);
        return ADDR_REGBASE + {2'h0, n, 2'h0};
    endfunction

    // poll until not busy; done must be up once it drops
    task automatic waitIdle();
        logic [31:0] rd;
        logic [1:0]  rs;
        int          n;
        n = 0;
        do begin
            axiRead(ADDR_STATUS, rd, rs);
            n++;
        end while (rd[0] !== 1'h0 && n < 50);
        if (rd[0] !== 1'h0) bail();
        check("done", {31'h0, rd[1]}, 32'h1);
    endtask

    // preset operands and flags, launch, then judge result, source, flags
    task automatic doOp(input logic [7:0] opc, input logic [3:0] d, s,
                        input logic [2:0] b, input logic sel,
                        input logic [7:0] dv, sv, fl);
        logic [31:0] rd;
        logic [1:0]  rs;
        logic [7:0]  r, f, m;
        r = dv;
        f = fl;
        m = 8'hFF;
        case (opc)
            OPC_AND_RR: begin
                r = dv & sv;
                f[FLAG_Z] = (r == 8'h00);
                f[FLAG_S] = r[7];
                f[FLAG_V] = 1'h0;
            end
            OPC_BCLRSET: r[b] = sel;
            OPC_ADD_RR: begin
                r = dv + sv;
                m = 8'h00; // sum flags are not modelled
            end
            default: begin
                if (opc == OPC_BINV) r[b] = ~dv[b];
                if (opc == OPC_BAND && sel) r[b] = dv[b] & sv[0];
                if (opc == OPC_BAND && !sel) r[0] = dv[0] & sv[b];
                f[FLAG_Z] = (opc == OPC_BCP) ? (dv[0] == sv[b])
                                             : (r == 8'h00);
                f[FLAG_S] = 1'h0;
                m[FLAG_V] = 1'h0; // overflow undefined after bit ops
            end
        endcase
        axiWrite(regAddr(d), {24'h0, dv}, 4'h1, rs);
        axiWrite(regAddr(s), {24'h0, sv}, 4'h1, rs);
        axiWrite(ADDR_FLAGS, {24'h0, fl}, 4'h1, rs);
        axiWrite(ADDR_CTRL, {8'h00, d, b, sel, 4'h0, s, opc}, 4'h7, rs);
        waitIdle();
        axiRead(regAddr(d), rd, rs);
        check("result", rd, {24'h0, r});
        axiRead(regAddr(s), rd, rs);
        check("source", rd, {24'h0, sv});
        axiRead(ADDR_FLAGS, rd, rs);
        check("flags", rd & {24'h0, m}, {24'h0, f & m});
    endtask

    task automatic testReset();
        logic [31:0] rd;
        logic [1:0]  rs;
        axiRead(ADDR_FLAGS, rd, rs);
        check("flags reset", rd, {24'h0, FLAGS_RST});
        axiRead(regAddr(4'hF), rd, rs);
        check("reg reset", rd, {24'h0, REG_RST});
    endtask

    task automatic testAnd();
        doOp(OPC_AND_RR, 4'h1, 4'h2, 3'h0, 1'h0, 8'h12, 8'h03, 8'hFC);
        doOp(OPC_AND_RR, 4'hF, 4'h0, 3'h0, 1'h0, 8'h80, 8'hF0, 8'h40);
        doOp(OPC_AND_RR, 4'h3, 4'h4, 3'h0, 1'h0, 8'h0F, 8'hF0, 8'h10);
    endtask

    // both operand directions at index 1 and the highest index 7
    task automatic testBitAnd();
        for (int i = 0; i < 4; i++) begin
            doOp(OPC_BAND, 4'h1, 4'h2, i[0] ? 3'h7 : 3'h1, i[1],
                 8'h87, 8'h05, 8'hFC);
        end
        doOp(OPC_BAND, 4'h5, 4'h6, 3'h0, 1'h0, 8'h01, 8'h00, 8'h80);
    endtask

    task automatic testCompare();
        doOp(OPC_BCP, 4'h1, 4'h2, 3'h1, 1'h0, 8'h07, 8'h01, 8'hC0);
        doOp(OPC_BCP, 4'h1, 4'h2, 3'h7, 1'h0, 8'h07, 8'h80, 8'h3C);
    endtask

    task automatic testInvert();
        doOp(OPC_BINV, 4'h1, 4'h2, 3'h1, 1'h0, 8'h07, 8'h55, 8'hFC);
        doOp(OPC_BINV, 4'h1, 4'h2, 3'h0, 1'h0, 8'h01, 8'h55, 8'h20);
        doOp(OPC_BINV, 4'h1, 4'h2, 3'h7, 1'h0, 8'h7F, 8'h55, 8'h00);
    endtask

    task automatic testClearSet();
        doOp(OPC_BCLRSET, 4'h1, 4'h2, 3'h1, 1'h0, 8'h07, 8'hAA, 8'hFC);
        doOp(OPC_BCLRSET, 4'h1, 4'h2, 3'h3, 1'h1, 8'h07, 8'hAA, 8'h00);
        doOp(OPC_BCLRSET, 4'h1, 4'h2, 3'h7, 1'h0, 8'hFF, 8'hAA, 8'h54);
    endtask

    task automatic testAdd();
        doOp(OPC_ADD_RR, 4'h1, 4'h2, 3'h0, 1'h0, 8'h12, 8'h03, 8'h00);
        doOp(OPC_ADD_RR, 4'h7, 4'h8, 3'h0, 1'h0, 8'hF0, 8'h20, 8'h00);
    endtask

    task automatic testUnmapped();
        logic [31:0] rd;
        logic [1:0]  rs;
        axiRead(8'h20, rd, rs);
        check("hole data", rd, BUS_RST);
        check("hole read resp", {30'h0, rs}, {30'h0, RESP_ERR});
        axiWrite(8'h20, 32'h000000FF, 4'hF, rs);
        check("hole write resp", {30'h0, rs}, {30'h0, RESP_ERR});
        // an opcode outside the set runs but raises the bad-op status bit
        axiWrite(ADDR_CTRL, 32'h000000FF, 4'h1, rs);
        waitIdle();
        axiRead(ADDR_STATUS, rd, rs);
        check("bad opcode status", rd, 32'h00000006);
    endtask

    // reset for twelve cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        testReset();
        testAnd();
        testBitAnd();
        testCompare();
        testInvert();
        testClearSet();
        testAdd();
        testUnmapped();
        results();
    end
endmodule

bind lbalu_top lbalu_top_props u_props (.clk(clk), .rst(rst),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
